// >>> hdl/status_core.sv
// Purpose: Status reporting and common-command layer behind the remote bus.
// Assumes: prior_busy_in is high while an earlier command still executes.
// Notes:   One reply is buffered; a new reply overwrites an unread one.
`timescale 1ns/100ps
module status_core #(
	parameter logic [31:0] MODEL_ID = 32'h43543031, // Arbitrary value.
	parameter logic [31:0] MAKER_ID = 32'h4d4b5231, // Arbitrary value.
	parameter logic [6:0]  FW_VER   = 7'h01         // Arbitrary value, 1 to 99.
)(
	input  wire logic                 mclk_in,
	input  wire logic                 reset_n_in,
	input  wire status_pkg::cmd_req_t cmd_in,
	input  wire status_pkg::suffix_t  suffix_in,
	input  wire status_pkg::bus_ev_t  bus_in,
	input  wire status_pkg::meas_ev_t meas_in,
	input  wire logic                 talk_only_in,
	input  wire logic                 prior_busy_in,
	input  wire logic                 exe_err_in,
	input  wire logic [11:0]          selftest_fail_in,
	output logic                      cmd_ready_out,
	output status_pkg::resp_t         resp_out,
	output logic [7:0]                status_byte_out,
	output logic                      srq_out,
	output logic                      talker_out,
	output logic                      listener_out,
	output logic                      remote_out,
	output logic                      preset_out,
	output logic                      trigger_out,
	output logic                      save_out,
	output logic                      recall_out,
	output logic [3:0]                slot_out,
	output status_pkg::unit_t         unit_out,
	output logic                      unit_valid_out
);
	import status_pkg::*;

	logic [7:0] esr_r, ese_r, sre_r, cev_r, cen_r, fev_r, fen_r, stb_r;
	logic       mss_q_r, rqs_r, talk_r, lstn_r, rem_r;
	logic       wait_r, opc_r, opcq_r, ready_r;
	logic [7:0] obuf_r [QDEPTH];
	logic [4:0] olen_r, rptr_r;
	resp_t      resp_r;
	logic       preset_r, trig_r, sav_r, rcl_r, unit_v_r;
	logic [3:0] slot_r;
	unit_t      unit_r;

	logic       acc, done, rd_ok, rd_empty, slot_bad, cme_set, exe_set, qye_set;
	logic       clr_all, mss, ld_go;
	logic [7:0] stb_c, esr_set, cev_set, fev_set;
	logic [7:0] ld_b [QDEPTH];
	logic [4:0] ld_n, base;
	logic [11:0] num;
	logic [3:0] dg [4];
	logic [2:0] cnt;
	sfx_res_t   sfx;

	function automatic logic is_op(input cmd_op_t o);
		return acc && (cmd_in.op == o);
	endfunction : is_op

	function automatic logic [7:0] upper(input logic [7:0] c);
		return (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
	endfunction : upper

	// Unused character slots are zeroed so each suffix matches one key.
	function automatic sfx_res_t decode_sfx(input suffix_t s);
		logic [23:0] k;
		sfx_res_t    r;
		k = {upper(s.c0), (s.len > 2'd1) ? upper(s.c1) : 8'h00,
			(s.len > 2'd2) ? upper(s.c2) : 8'h00};
		if (s.len == 2'd0)
			k = 24'h000000;
		r.ok = 1'b1;
		r.unit = s.is_time ? U_NS : U_HZ;
		if (!s.is_time) begin
			unique case (k)
				24'h000000, 24'h485a00: r.unit = U_HZ;
				24'h470000, 24'h47485a: r.unit = U_GHZ;
				24'h4d4100, 24'h4d485a: r.unit = U_MHZ;
				24'h4b0000, 24'h4b485a: r.unit = U_KHZ;
				default:                r.ok = 1'b0;
			endcase
		end else begin
			unique case (k)
				24'h000000, 24'h4e5300, 24'h4e0000: r.unit = U_NS;
				24'h530000:             r.unit = U_S;
				24'h4d5300, 24'h4d0000: r.unit = U_MS;
				24'h555300, 24'h550000: r.unit = U_US;
				default:                r.ok = 1'b0;
			endcase
		end
		return r;
	endfunction : decode_sfx

	assign acc = cmd_in.valid & ready_r;
	assign done = !prior_busy_in;
	assign sfx = decode_sfx(suffix_in);
	assign rd_ok = bus_in.byte_req & talk_r & (olen_r != 5'h00);
	assign rd_empty = bus_in.byte_req & talk_r & (olen_r == 5'h00);
	assign slot_bad = cmd_in.arg > SLOT_MAX;
	assign clr_all = is_op(C_CLS) | bus_in.dev_clear;
	assign cme_set = is_op(C_BAD) | (suffix_in.valid & !sfx.ok)
		| (bus_in.get & bus_in.in_message);
	assign exe_set = exe_err_in
		| ((is_op(C_SAVE) | is_op(C_RECALL)) & slot_bad);
	assign qye_set = rd_empty | (ld_go & (olen_r != 5'h00) & !clr_all);

	// RQC, DDE and URQ have no source, so they stay at zero.
	always_comb begin
		esr_set = 8'h00;
		esr_set[ESR_OPC] = opc_r & done;
		esr_set[ESR_QYE] = qye_set;
		esr_set[ESR_EXE] = exe_set;
		esr_set[ESR_CME] = cme_set;
		cev_set = 8'h00;
		cev_set[CEV_MEAS] = meas_in.count_done;
		cev_set[CEV_STAT] = meas_in.analysis_done;
		fev_set = 8'h00;
		fev_set[FEV_UNCAL] = meas_in.uncal;
		fev_set[FEV_LIMIT] = meas_in.limit_fail & meas_in.template_on;
	end

	always_comb begin
		stb_c = 8'h00;
		stb_c[STB_END] = |(cev_r & cen_r);
		stb_c[STB_ERR] = |(fev_r & fen_r);
		stb_c[STB_MAV] = olen_r != 5'h00;
		stb_c[STB_ESB] = |(esr_r & ese_r);
		mss = |(stb_c & sre_r);
	end

	// Reading an event register clears it; a new event in that cycle still lands.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			esr_r <= ESR_RST;
			cev_r <= REG_RST;
			fev_r <= REG_RST;
		end else begin
			esr_r <= ((is_op(C_CLS) | is_op(C_EV_Q)) ? 8'h00 : esr_r) | esr_set;
			cev_r <= ((is_op(C_CLS) | is_op(C_CEV_Q)) ? 8'h00 : cev_r) | cev_set;
			fev_r <= ((is_op(C_CLS) | is_op(C_FEV_Q)) ? 8'h00 : fev_r) | fev_set;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ese_r <= REG_RST;
			sre_r <= REG_RST;
			cen_r <= REG_RST;
			fen_r <= REG_RST;
		end else begin
			if (is_op(C_EV_EN))
				ese_r <= cmd_in.arg;
			if (is_op(C_SR_EN))
				sre_r <= cmd_in.arg & ~(8'h01 << STB_MSS);
			if (is_op(C_CEV_EN))
				cen_r <= cmd_in.arg;
			if (is_op(C_FEV_EN))
				fen_r <= cmd_in.arg;
		end
	end

	// The poll byte carries the request flag; it holds until a poll reads it.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stb_r <= REG_RST;
			mss_q_r <= 1'b0;
			rqs_r <= 1'b0;
		end else begin
			mss_q_r <= mss;
			rqs_r <= (mss & !mss_q_r) | (rqs_r & !bus_in.poll_read);
			stb_r <= stb_c | ({7'h00, rqs_r} << STB_MSS);
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			talk_r <= 1'b0;
			lstn_r <= 1'b0;
			rem_r <= 1'b0;
		end else begin
			if (talk_only_in || bus_in.my_talk)
				talk_r <= 1'b1;
			else if (bus_in.my_listen || bus_in.untalk)
				talk_r <= 1'b0;
			if (bus_in.my_listen)
				lstn_r <= 1'b1;
			else if (bus_in.my_talk || bus_in.unlisten)
				lstn_r <= 1'b0;
			if (!bus_in.ren || bus_in.go_local)
				rem_r <= 1'b0;
			else if (bus_in.my_listen)
				rem_r <= 1'b1;
		end
	end

	// Holding ready low is how later commands wait; the parser must obey it.
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_r <= 1'b0;
			opc_r <= 1'b0;
			opcq_r <= 1'b0;
			ready_r <= 1'b1;
		end else begin
			wait_r <= !bus_in.dev_clear & (is_op(C_WAI) | (wait_r & !done));
			opc_r <= !clr_all & !is_op(C_PRESET) & (is_op(C_OPC) | (opc_r & !done));
			opcq_r <= !clr_all & !is_op(C_PRESET) & (is_op(C_OPC_Q) | (opcq_r & !done));
			ready_r <= !(is_op(C_WAI) | is_op(C_OPC_Q)
				| ((wait_r | opcq_r) & !done & !bus_in.dev_clear));
		end
	end

	always_comb begin
		ld_go = 1'b0;
		num = 12'h000;
		base = 5'h00;
		for (int i = 0; i < QDEPTH; i++)
			ld_b[i] = CH_LF;
		if (opcq_r && done) begin
			ld_go = 1'b1;
			num = 12'h001;
		end else if (acc) begin
			ld_go = 1'b1;
			unique case (cmd_in.op)
				C_ID_Q: begin
					base = 5'h0c;
					num = {5'h00, FW_VER};
					for (int i = 0; i < 4; i++) begin
						ld_b[i] = MODEL_ID[31 - 8 * i -: 8];
						ld_b[5 + i] = MAKER_ID[31 - 8 * i -: 8];
					end
					ld_b[4] = CH_COMMA;
					ld_b[9] = CH_COMMA;
					ld_b[10] = CH_ZERO;
					ld_b[11] = CH_COMMA;
				end
				C_SELFTEST_Q: num = selftest_fail_in;
				C_EV_EN_Q:    num = {4'h0, ese_r};
				C_EV_Q:       num = {4'h0, esr_r};
				C_SR_EN_Q:    num = {4'h0, sre_r};
				C_STB_Q:      num = {4'h0, stb_c | ({7'h00, mss} << STB_MSS)};
				C_CEV_EN_Q:   num = {4'h0, cen_r};
				C_CEV_Q:      num = {4'h0, cev_r};
				C_FEV_EN_Q:   num = {4'h0, fen_r};
				C_FEV_Q:      num = {4'h0, fev_r};
				default:      ld_go = 1'b0;
			endcase
		end
		dg[0] = 4'(num % 12'h00a);
		dg[1] = 4'((num / 12'h00a) % 12'h00a);
		dg[2] = 4'((num / 12'h064) % 12'h00a);
		dg[3] = 4'(num / 12'h3e8);
		cnt = (num >= 12'h3e8) ? 3'h4 : (num >= 12'h064) ? 3'h3 : (num >= 12'h00a) ? 3'h2 : 3'h1;
		for (int k = 0; k < 4; k++)
			if (3'(k) < cnt)
				ld_b[4'(base + 5'(k))] = CH_ZERO + {4'h0, dg[2'(cnt - 3'h1 - 3'(k))]};
		ld_n = base + {2'h0, cnt} + 5'h01;
	end

	always_ff @(posedge mclk_in) begin
		if (ld_go)
			for (int i = 0; i < QDEPTH; i++)
				obuf_r[i] <= ld_b[i];
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			olen_r <= 5'h00;
			rptr_r <= 5'h00;
			resp_r <= '0;
		end else begin
			resp_r.valid <= rd_ok;
			resp_r.last <= rd_ok & (rptr_r + 5'h01 == olen_r);
			resp_r.data <= obuf_r[rptr_r[3:0]];
			if (clr_all) begin
				olen_r <= 5'h00;
				rptr_r <= 5'h00;
			end else if (ld_go) begin
				olen_r <= ld_n;
				rptr_r <= 5'h00;
			end else if (rd_ok) begin
				if (rptr_r + 5'h01 == olen_r) begin
					olen_r <= 5'h00;
					rptr_r <= 5'h00;
				end else
					rptr_r <= rptr_r + 5'h01;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			preset_r <= 1'b0;
			trig_r <= 1'b0;
			sav_r <= 1'b0;
			rcl_r <= 1'b0;
			slot_r <= 4'h0;
			unit_r <= U_HZ;
			unit_v_r <= 1'b0;
		end else begin
			preset_r <= is_op(C_PRESET);
			trig_r <= is_op(C_TRG) | (bus_in.get & !bus_in.in_message);
			sav_r <= is_op(C_SAVE) & !slot_bad;
			rcl_r <= is_op(C_RECALL) & !slot_bad;
			if ((is_op(C_SAVE) | is_op(C_RECALL)) & !slot_bad)
				slot_r <= cmd_in.arg[3:0];
			unit_v_r <= suffix_in.valid & sfx.ok;
			if (suffix_in.valid & sfx.ok)
				unit_r <= sfx.unit;
		end
	end

	assign cmd_ready_out = ready_r;
	assign resp_out = resp_r;
	assign status_byte_out = stb_r;
	assign srq_out = rqs_r;
	assign talker_out = talk_r;
	assign listener_out = lstn_r;
	assign remote_out = rem_r;
	assign preset_out = preset_r;
	assign trigger_out = trig_r;
	assign save_out = sav_r;
	assign recall_out = rcl_r;
	assign slot_out = slot_r;
	assign unit_out = unit_r;
	assign unit_valid_out = unit_v_r;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	a_unused_bits_zero: assert property (esr_r[ESR_RQC] == 1'b0
		&& esr_r[ESR_URQ] == 1'b0 && esr_r[ESR_DDE] == 1'b0)
		else $error("Unused event bit set.");
	a_opc_sets_bit: assert property (opc_r && done |=> esr_r[ESR_OPC])
		else $error("Completion did not set event bit 0.");
	a_wait_blocks: assert property (wait_r && !done && !bus_in.dev_clear |=> !ready_r)
		else $error("Command accepted while waiting.");
	a_talk_release: assert property (bus_in.my_listen && !talk_only_in
		&& !bus_in.my_talk |=> !talk_r)
		else $error("Talker not released by listen address.");
	a_listen_release: assert property (bus_in.my_talk && !bus_in.my_listen
		|=> !lstn_r)
		else $error("Listener not released by talk address.");
	a_mav_follows: assert property (olen_r != 5'h00 |=> stb_r[STB_MAV])
		else $error("Message available missing.");
	a_cls_keeps_en: assert property (is_op(C_CLS) |=> ese_r == $past(ese_r)
		&& sre_r == $past(sre_r) && olen_r == 5'h00)
		else $error("Clear status disturbed enables or left a reply.");
	a_empty_read_err: assert property (rd_empty |=> esr_r[ESR_QYE])
		else $error("Empty read did not flag a query error.");
	a_bad_cmd_err: assert property (is_op(C_BAD) |=> esr_r[ESR_CME])
		else $error("Bad command did not flag a command error.");
	a_slot_range: assert property ((is_op(C_SAVE) || is_op(C_RECALL)) && slot_bad
		|=> esr_r[ESR_EXE] && !sav_r && !rcl_r)
		else $error("Bad slot not rejected.");
	a_srq_on_rise: assert property (mss && !mss_q_r |=> rqs_r ##1 stb_r[STB_MSS])
		else $error("Service request not raised.");
	a_opcq_reply: assert property (opcq_r && done && !clr_all
		|=> olen_r == 5'h02 && obuf_r[0] == CH_ZERO + 8'h01)
		else $error("Completion query reply wrong.");
	c_id_query: cover property (is_op(C_ID_Q) ##[1:60] resp_r.last);
	c_srq_poll: cover property (rqs_r ##1 bus_in.poll_read);
	c_wait_done: cover property (wait_r && !done ##1 wait_r && done);
endmodule : status_core

// >>> pkg/status_pkg.sv
// Purpose: Shared constants, command codes and carriers for the status-reporting core.
// Assumes: Commands arrive already parsed into one opcode plus one argument byte.
// Notes:   Bit positions follow the customary status byte and event register layout.
package status_pkg;
	localparam int QDEPTH = 16;
	localparam int ESR_OPC = 0;
	localparam int ESR_RQC = 1;
	localparam int ESR_QYE = 2;
	localparam int ESR_DDE = 3;
	localparam int ESR_EXE = 4;
	localparam int ESR_CME = 5;
	localparam int ESR_URQ = 6;
	localparam int ESR_PON = 7;
	localparam int STB_END = 0;
	localparam int STB_ERR = 1;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_MSS = 6;
	localparam int CEV_MEAS = 0;
	localparam int CEV_STAT = 1;
	localparam int FEV_UNCAL = 0;
	localparam int FEV_LIMIT = 1;
	localparam logic [7:0] ESR_RST = 8'h80;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] SLOT_MAX = 8'h09;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_ZERO = 8'h30;

	typedef enum logic [4:0] {
		C_ID_Q, C_PRESET, C_SELFTEST_Q, C_OPC, C_OPC_Q, C_WAI, C_CLS,
		C_EV_EN, C_EV_EN_Q, C_EV_Q, C_SR_EN, C_SR_EN_Q, C_STB_Q, C_TRG,
		C_RECALL, C_SAVE, C_CEV_EN, C_CEV_EN_Q, C_CEV_Q,
		C_FEV_EN, C_FEV_EN_Q, C_FEV_Q, C_BAD
	} cmd_op_t;

	typedef enum logic [2:0] {U_HZ, U_KHZ, U_MHZ, U_GHZ, U_S, U_MS, U_US, U_NS} unit_t;

	typedef struct packed {
		logic       valid;
		cmd_op_t    op;
		logic [7:0] arg;
	} cmd_req_t;

	typedef struct packed {
		logic       valid;
		logic       is_time;
		logic [1:0] len;
		logic [7:0] c0;
		logic [7:0] c1;
		logic [7:0] c2;
	} suffix_t;

	typedef struct packed {
		logic my_talk;
		logic my_listen;
		logic untalk;
		logic unlisten;
		logic get;
		logic in_message;
		logic dev_clear;
		logic go_local;
		logic ren;
		logic poll_read;
		logic byte_req;
	} bus_ev_t;

	typedef struct packed {
		logic count_done;
		logic analysis_done;
		logic uncal;
		logic limit_fail;
		logic template_on;
	} meas_ev_t;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} resp_t;

	typedef struct packed {
		logic  ok;
		unit_t unit;
	} sfx_res_t;
endpackage : status_pkg

// >>> tb/host_model.sv
// Purpose: Host controller model that pulses bus events and fetches reply bytes.
// Assumes: A reply byte shows one cycle after the request that asked for it.
// Notes:   The levels ren and in_message stay as last set.
`timescale 1ns/100ps
module host_model
	import status_pkg::*;
(
	input  wire logic              mclk_in,
	input  wire status_pkg::resp_t resp_in,
	output status_pkg::bus_ev_t    bus_out
);
	bus_ev_t pulse_r = '0;
	logic    ren_r   = 1'b0;
	logic    msg_r   = 1'b0;
	always_comb begin
		bus_out = pulse_r;
		bus_out.ren = ren_r;
		bus_out.in_message = msg_r;
	end
	task automatic levels(input logic ren, input logic msg);
		ren_r = ren;
		msg_r = msg;
	endtask : levels
	task automatic send(input bus_ev_t ev);
		pulse_r = ev;
		@(posedge mclk_in);
		#1;
		pulse_r = '0;
	endtask : send
	// A byte that never shows is kept as unknown, so the caller's compare fails.
	task automatic fetch(output logic [127:0] b);
		bus_ev_t ev;
		ev = '0;
		ev.byte_req = 1'b1;
		b = '0;
		for (int n = 0; n < 16; n++) begin
			send(ev);
			b = {b[119:0], (resp_in.valid === 1'b1) ? resp_in.data : 8'hxx};
			if (resp_in.last === 1'b1) break;
			@(posedge mclk_in);
			#1;
		end
	endtask : fetch
endmodule : host_model

// >>> tb/gpib_status_reporting_tb.sv
// Purpose: Self-checking bench for the status-reporting core.
// Assumes: The host model only fetches replies while the core is talker.
// Notes:   Random values come from a fixed-seed shift register.
`timescale 1ns/100ps
module gpib_status_reporting_tb;
	import status_pkg::*;
	localparam logic [31:0] MODEL = 32'h54435631; // Arbitrary value.
	localparam logic [31:0] MAKER = 32'h4d4b4531; // Arbitrary value.
	localparam logic [6:0]  FW    = 7'h2a;        // Arbitrary value.
	localparam bus_ev_t EV_TALK = 11'h400;
	localparam bus_ev_t EV_LSN  = 11'h200;
	localparam bus_ev_t EV_GET  = 11'h040;
	localparam bus_ev_t EV_CLR  = 11'h010;
	localparam bus_ev_t EV_LOC  = 11'h008;
	localparam bus_ev_t EV_POLL = 11'h002;
	localparam bus_ev_t EV_BYTE = 11'h001;
	logic        mclk_in = 1'b0, reset_n_in = 1'b0;
	cmd_req_t    cmd_in = '0;
	suffix_t     suffix_in = '0;
	bus_ev_t     bus_in;
	meas_ev_t    meas_in = '0;
	logic        talk_only_in = 1'b0, prior_busy_in = 1'b0, exe_err_in = 1'b0;
	logic [11:0] selftest_fail_in = 12'h000;
	logic        cmd_ready_out, srq_out, talker_out, listener_out, remote_out;
	logic        preset_out, trigger_out, save_out, recall_out, unit_valid_out;
	resp_t       resp_out;
	logic [7:0]  status_byte_out;
	logic [3:0]  slot_out;
	unit_t       unit_out;
	int          num_errors = 0, compares = 0;
	int          pn [5] = '{default: 0};
	logic [31:0] rnd = 32'h000106a8;
	logic [127:0] b;
	logic [7:0]  v;
	string       sfx [18] = '{"", "Hz", "g", "GHz", "Ma", "mhz", "k", "KHZ",
		"", "n", "Ns", "s", "m", "Ms", "u", "Us", "m", "hz"};
	unit_t       sfu [16] = '{U_HZ, U_HZ, U_GHZ, U_GHZ, U_MHZ, U_MHZ, U_KHZ, U_KHZ,
		U_NS, U_NS, U_NS, U_S, U_MS, U_MS, U_US, U_US};

	status_core #(.MODEL_ID(MODEL), .MAKER_ID(MAKER), .FW_VER(FW)) u_status_core (
		.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cmd_in(cmd_in),
		.suffix_in(suffix_in), .bus_in(bus_in), .meas_in(meas_in),
		.talk_only_in(talk_only_in), .prior_busy_in(prior_busy_in),
		.exe_err_in(exe_err_in), .selftest_fail_in(selftest_fail_in),
		.cmd_ready_out(cmd_ready_out), .resp_out(resp_out),
		.status_byte_out(status_byte_out), .srq_out(srq_out), .talker_out(talker_out),
		.listener_out(listener_out), .remote_out(remote_out), .preset_out(preset_out),
		.trigger_out(trigger_out), .save_out(save_out), .recall_out(recall_out),
		.slot_out(slot_out), .unit_out(unit_out), .unit_valid_out(unit_valid_out));
	host_model u_host_model (.mclk_in(mclk_in), .resp_in(resp_out), .bus_out(bus_in));

	always #2.5 mclk_in = ~mclk_in;
	// Pulses last one cycle; counting at the falling edge samples them mid-cycle.
	always @(negedge mclk_in) begin
		if (preset_out === 1'b1) pn[0]++;
		if (trigger_out === 1'b1) pn[1]++;
		if (save_out === 1'b1) pn[2]++;
		if (recall_out === 1'b1) pn[3]++;
		if (unit_valid_out === 1'b1) pn[4]++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [127:0] asc(input int n);
		logic [127:0] r;
		int           k;
		r = {120'h0, CH_LF};
		k = 1;
		do begin
			r[k*8 +: 8] = 8'(CH_ZERO + n % 10);
			n = n / 10;
			k++;
		end while (n > 0);
		return r;
	endfunction : asc
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : tick
	task automatic cmd(input cmd_op_t op, input logic [7:0] arg);
		for (int n = 0; n < 50 && cmd_ready_out !== 1'b1; n++) tick(1);
		cmd_in = '{valid: 1'b1, op: op, arg: arg};
		tick(1);
		cmd_in.valid = 1'b0;
		// One edge passes so that valid is never lowered and raised in one step.
		tick(1);
	endtask : cmd
	task automatic q(input cmd_op_t op, input logic [7:0] arg, input logic [127:0] exp);
		cmd(op, arg);
		tick(3);
		chk(status_byte_out[STB_MAV], 1'b1);
		u_host_model.fetch(b);
		chk(b, exp);
		tick(3);
		chk(status_byte_out[STB_MAV], 1'b0);
	endtask : q
	task automatic mp(input meas_ev_t m);
		meas_in = m;
		tick(1);
		meas_in = '{template_on: m.template_on, default: 1'b0};
		tick(3);
	endtask : mp
	task automatic end_of_test;
		$display("Mismatches %0d, comparisons %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end
	initial begin
		tick(3);
		reset_n_in = 1'b1;
		chk({cmd_ready_out, status_byte_out}, 9'h100);
		u_host_model.levels(1'b1, 1'b0);
		u_host_model.send(EV_LSN);
		tick(1);
		chk({talker_out, listener_out, remote_out}, 3'h3);
		u_host_model.send(EV_TALK);
		tick(1);
		chk({talker_out, listener_out, remote_out}, 3'h5);
		u_host_model.send(EV_LOC);
		tick(1);
		chk(remote_out, 1'b0);
		q(C_EV_Q, 8'h00, asc(128));
		q(C_EV_Q, 8'h00, asc(0));
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			v = (i == 0) ? 8'hff : (i == 3) ? 8'h00 : rnd[7:0];
			cmd(C_EV_EN, v);
			q(C_EV_EN_Q, 8'h00, asc(v));
			cmd(C_SR_EN, v);
			q(C_SR_EN_Q, 8'h00, asc(v & 8'hbf));
		end
		chk(srq_out, 1'b1);
		u_host_model.send(EV_POLL);
		tick(1);
		chk(srq_out, 1'b0);
		u_host_model.send(EV_BYTE);
		cmd(C_SR_EN_Q, 8'h00);
		cmd(C_EV_EN_Q, 8'h00);
		tick(3);
		u_host_model.fetch(b);
		chk(b, asc(0));
		q(C_EV_Q, 8'h00, asc(1 << ESR_QYE));
		cmd(C_BAD, 8'h00);
		exe_err_in = 1'b1;
		tick(1);
		exe_err_in = 1'b0;
		u_host_model.levels(1'b0, 1'b1);
		u_host_model.send(EV_GET);
		u_host_model.levels(1'b0, 1'b0);
		tick(1);
		u_host_model.send(EV_GET);
		cmd(C_TRG, 8'h00);
		tick(3);
		chk(pn[1], 2);
		q(C_EV_Q, 8'h00, asc((1 << ESR_CME) | (1 << ESR_EXE)));
		rnd = lfsr(rnd);
		cmd(C_SAVE, 8'h09);
		cmd(C_RECALL, 8'(rnd % 10));
		cmd(C_SAVE, 8'h0a);
		cmd(C_RECALL, 8'hff);
		tick(3);
		chk({slot_out, pn[2], pn[3]}, {4'(rnd % 10), 32'h1, 32'h1});
		q(C_EV_Q, 8'h00, asc(1 << ESR_EXE));
		for (int i = 0; i < 18; i++) begin
			suffix_in = '{valid: 1'b1, is_time: (i >= 8 && i < 16) || i == 17,
				len: 2'(sfx[i].len()), c0: sfx[i][0], c1: sfx[i][1], c2: sfx[i][2]};
			tick(1);
			suffix_in.valid = 1'b0;
			tick(2);
			if (i < 16) chk(unit_out, sfu[i]);
		end
		chk(pn[4], 16);
		q(C_EV_Q, 8'h00, asc(1 << ESR_CME));
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			selftest_fail_in = (i == 0) ? 12'h000 : (i == 1) ? 12'h800 : rnd[11:0];
			q(C_SELFTEST_Q, 8'h00, asc(selftest_fail_in));
		end
		q(C_ID_Q, 8'h00, {8'h00, MODEL, CH_COMMA, MAKER, CH_COMMA, CH_ZERO, CH_COMMA, 24'h0}
			| asc(FW));
		cmd(C_OPC, 8'h00);
		q(C_EV_Q, 8'h00, asc(1 << ESR_OPC));
		cmd(C_PRESET, 8'h00);
		prior_busy_in = 1'b1;
		cmd(C_OPC_Q, 8'h00);
		tick(5);
		chk({cmd_ready_out, status_byte_out[STB_MAV]}, 2'h0);
		prior_busy_in = 1'b0;
		tick(3);
		u_host_model.fetch(b);
		chk(b, asc(1));
		cmd(C_PRESET, 8'h00);
		prior_busy_in = 1'b1;
		cmd(C_WAI, 8'h00);
		tick(3);
		chk(cmd_ready_out, 1'b0);
		prior_busy_in = 1'b0;
		tick(3);
		chk({cmd_ready_out, pn[0]}, {1'b1, 32'h2});
		cmd(C_EV_EN, 8'h20);
		cmd(C_BAD, 8'h00);
		tick(3);
		chk(status_byte_out, 8'h20);
		cmd(C_SR_EN, 8'h20);
		tick(3);
		chk({srq_out, status_byte_out}, 9'h160);
		u_host_model.send(EV_POLL);
		tick(2);
		chk(srq_out, 1'b0);
		cmd(C_CEV_EN, 8'h03);
		cmd(C_FEV_EN, 8'h03);
		mp(5'h10);
		chk(status_byte_out, 8'h21);
		mp(5'h04);
		chk(status_byte_out, 8'h23);
		cmd(C_CLS, 8'h00);
		tick(3);
		chk(status_byte_out, 8'h00);
		q(C_EV_EN_Q, 8'h00, asc(8'h20));
		q(C_CEV_EN_Q, 8'h00, asc(8'h03));
		mp(5'h08);
		q(C_CEV_Q, 8'h00, asc(1 << CEV_STAT));
		mp(5'h02);
		q(C_FEV_Q, 8'h00, asc(0));
		mp(5'h03);
		q(C_FEV_Q, 8'h00, asc(1 << FEV_LIMIT));
		talk_only_in = 1'b1;
		u_host_model.send(EV_LSN);
		tick(1);
		chk(talker_out, 1'b1);
		cmd(C_SR_EN_Q, 8'h00);
		tick(3);
		u_host_model.send(EV_CLR);
		tick(3);
		chk(status_byte_out[STB_MAV], 1'b0);
		end_of_test();
	end
endmodule : gpib_status_reporting_tb
